// ==== src/conv_ctrl_pkg.sv ====
package conv_ctrl_pkg;

  // Register word byte addresses on the Avalon-MM slave.
  localparam logic [3:0] CTRL0_ADDR = 4'h0;
  localparam logic [3:0] CTRL1_ADDR = 4'h4;
  localparam logic [3:0] DATA_ADDR = 4'h8;
  localparam logic [3:0] STATUS_ADDR = 4'hC;
  localparam logic [3:0] MASK_ADDR = 4'h0;

  // Control word 0 field positions.
  localparam int SEL_LSB = 0;
  localparam int CONTINUOUS_SELECT_BIT = 4;
  localparam int REFOUT_BIT = 5;
  localparam int REFLO_BIT = 6;
  localparam int EN_BIT = 7;
  localparam int BUF_LSB = 8;

  // Control word 1 field positions.
  localparam int REFHI_BIT = 0;
  localparam int MASK_BIT = 8;

  // Values after reset.
  localparam logic [9:0] CTRL0_RESET = 10'h000;
  localparam logic [1:0] CTRL1_RESET = 2'h0;

  // Cycle counts at 100 MHz clock.
  localparam int CLK_MHZ = 100;
  localparam int FIRST_CYCLES = 5129;
  localparam int POWERUP_CYCLES = 40;
  localparam int CADENCE_CYCLES = 256;

  // Input stage configurations.
  localparam logic [1:0] STAGE_UNBUF = 2'h0;
  localparam logic [1:0] STAGE_BUF = 2'h1;
  localparam logic [1:0] STAGE_OPAMP = 2'h2;

  typedef enum logic [1:0] {
    ST_IDLE,
    ST_POWERUP,
    ST_FIRST,
    ST_CONTINUOUS_SELECT
  } conv_state_e;

endpackage : conv_ctrl_pkg

// ==== src/cycle_timer.sv ====
`timescale 1ns/1ns
// Down counter that pulses done when a loaded count expires.
module cycle_timer
  import conv_ctrl_pkg::*;
(
  input wire logic clock, // System clock.
  input wire logic reset_n, // Synchronous reset, active low.
  input wire logic load, // Load a new count.
  input wire logic [12:0] count, // Cycles until done.
  input wire logic stop, // Abandon the running count.
  output logic done // One-cycle pulse on expiry.
);

  logic [12:0] cnt_r;
  logic [12:0] cnt_nxt;
  logic run_r;
  logic run_nxt;
  logic done_nxt;

  // Next count; done rises on the edge that takes the count from one to zero.
  always_comb begin
    cnt_nxt = cnt_r;
    run_nxt = run_r;
    done_nxt = 1'b0;
    if (load) begin
      cnt_nxt = count;
      run_nxt = 1'b1;
    end else if (stop) begin
      run_nxt = 1'b0;
    end else if (run_r) begin
      if (cnt_r == 13'h0001) begin
        done_nxt = 1'b1;
        run_nxt = 1'b0;
      end
      cnt_nxt = cnt_r - 13'h0001;
    end
  end

  // Timer registers.
  always_ff @(posedge clock) begin
    if (!reset_n) begin
      cnt_r <= 13'h0000;
      run_r <= 1'b0;
      done <= 1'b0;
    end else begin
      cnt_r <= cnt_nxt;
      run_r <= run_nxt;
      done <= done_nxt;
    end
  end

endmodule : cycle_timer

// ==== src/conv_ctrl.sv ====
// Decided for this implementation: the register addresses and register access over Avalon-MM.
`timescale 1ns/1ns
// What this block does
// - Effective result is an 11-bit signed two's complement value.
// - Input multiplexer routes one of eight analog pins per input_select.
// - Input stage selects unbuffered, unity buffered or low-power opamp path.
// - Reference level or disable comes from high and low level bits.
// - First result after 5129 cycles, plus 40 when power-up needed.
// - conversion_enable clears at first result and stays clear afterwards.
// - Later results arrive every 256 cycles while continuous stays set.
// - Each 13-bit result stored in high byte and low byte bits 7:3.
// - Every completed conversion sets the status flag; irq follows it only while the mask bit is set.
// - Clearing continuous after the first result raises no new interrupt; pending one stays.
module conv_ctrl
  import conv_ctrl_pkg::*;
(
  input wire logic clock, // System clock, 100 MHz.
  input wire logic reset_n, // Synchronous reset, active low.
  input wire logic [3:0] avs_address, // Byte address.
  input wire logic avs_read, // Read request.
  input wire logic avs_write, // Write request.
  input wire logic [31:0] avs_writedata, // Write data.
  input wire logic [3:0] avs_byteenable, // Byte lanes.
  output logic [31:0] avs_readdata, // Read data.
  output logic avs_waitrequest, // Stall until answer.
  input wire logic [12:0] modulator_data, // Raw modulator sample.
  input wire logic analog_powered, // Analog section is up.
  output logic [2:0] analog_pin_sel, // Mux pin select.
  output logic [3:0] input_select, // Full input source code.
  output logic [1:0] stage_sel, // Input stage configuration.
  output logic [1:0] ref_level, // {high, low} reference level.
  output logic reference_out_pin, // Drive reference onto pin.
  output logic analog_power_up, // Request analog power.
  output logic irq // Level interrupt.
);

  conv_state_e state_r;
  conv_state_e state_nxt;
  logic [9:0] ctrl0_r;
  logic [9:0] ctrl0_nxt;
  logic [1:0] ctrl1_r;
  logic [1:0] ctrl1_nxt;
  logic [12:0] result_r;
  logic [12:0] result_nxt;
  logic status_r;
  logic status_nxt;
  logic mask_r;
  logic mask_nxt;
  logic [31:0] rdata_nxt;
  logic wait_r;
  logic wait_nxt;
  logic irq_nxt;
  logic [12:0] mod_s1_r;
  logic [12:0] mod_s2_r;
  logic [12:0] mod_s3_r;
  logic [12:0] sample_r;
  logic [12:0] sample_nxt;
  logic pwr_s1_r;
  logic pwr_s2_r;
  logic tmr_load;
  logic [12:0] tmr_count;
  logic tmr_stop;
  logic tmr_done;
  logic complete;
  logic wr_acc;
  logic rd_acc;

  // Returns the raw bits of one register word, reserved bits as zero.
  function automatic logic [31:0] reg_word(input logic [3:0] a,
      input logic [9:0] c0, input logic [1:0] c1, input logic [12:0] res,
      input logic st, input logic mk);
    logic [31:0] w;
    w = 32'h0000_0000;
    case (a)
      CTRL0_ADDR: w[9:0] = c0;
      CTRL1_ADDR: begin
        w[1:0] = c1;
        w[MASK_BIT] = mk;
      end
      DATA_ADDR: w[15:3] = res;
      STATUS_ADDR: w[0] = st;
      default: w = 32'h0000_0000;
    endcase
    return w;
  endfunction : reg_word

  // Folds the unused fourth stage code onto the unbuffered path.
  function automatic logic [1:0] stage_code(input logic [1:0] code);
    logic [1:0] s;
    s = code;
    if (code == 2'h3) begin
      s = STAGE_UNBUF;
    end
    return s;
  endfunction : stage_code

  // Two flip-flops on every input from the analog domain; a third stage
  // on the sample word lets the settle check compare two edges.
  always_ff @(posedge clock) begin
    if (!reset_n) begin
      mod_s1_r <= 13'h0000;
      mod_s2_r <= 13'h0000;
      mod_s3_r <= 13'h0000;
      sample_r <= 13'h0000;
      pwr_s1_r <= 1'b0;
      pwr_s2_r <= 1'b0;
    end else begin
      mod_s1_r <= modulator_data;
      mod_s2_r <= mod_s1_r;
      mod_s3_r <= mod_s2_r;
      sample_r <= sample_nxt;
      pwr_s1_r <= analog_powered;
      pwr_s2_r <= pwr_s1_r;
    end
  end

  // The bits of a word from the analog side need not all cross on one
  // edge, so only a value seen unchanged on two edges in a row is taken.
  always_comb begin
    sample_nxt = sample_r;
    if (mod_s2_r == mod_s3_r) begin
      sample_nxt = mod_s2_r;
    end
  end

  // Timer that sets first-result and cadence intervals.
  cycle_timer u_timer (
    .clock(clock),
    .reset_n(reset_n),
    .load(tmr_load),
    .count(tmr_count),
    .stop(tmr_stop),
    .done(tmr_done)
  );

  // A write lands at the edge where waitrequest is sampled low; a read is
  // fetched one edge earlier so that its data stand at that same edge.
  assign wr_acc = avs_write && !wait_r;
  assign rd_acc = avs_read && wait_r;

  // Conversion sequencer and register updates.
  always_comb begin
    state_nxt = state_r;
    ctrl0_nxt = ctrl0_r;
    ctrl1_nxt = ctrl1_r;
    result_nxt = result_r;
    mask_nxt = mask_r;
    tmr_load = 1'b0;
    tmr_count = 13'h0000;
    tmr_stop = 1'b0;
    complete = 1'b0;
    // Register writes; all fields of one control word may change in one access.
    if (wr_acc && avs_address == CTRL0_ADDR) begin
      if (avs_byteenable[0]) begin
        ctrl0_nxt[7:0] = avs_writedata[7:0];
      end
      if (avs_byteenable[1]) begin
        ctrl0_nxt[9:8] = avs_writedata[9:8];
      end
    end
    if (wr_acc && avs_address == CTRL1_ADDR) begin
      if (avs_byteenable[0]) begin
        ctrl1_nxt = avs_writedata[1:0];
      end
      if (avs_byteenable[1]) begin
        mask_nxt = avs_writedata[MASK_BIT];
      end
    end
    // Seeing the start costs a cycle and registering the flag another, so
    // each first-result load is trimmed to keep the interval exact from the edge that
    // takes the start write.
    case (state_r)
      ST_IDLE: begin
        if (ctrl0_r[EN_BIT]) begin
          if (!pwr_s2_r) begin
            // Analog section is off: let it power up first.
            state_nxt = ST_POWERUP;
            tmr_load = 1'b1;
            tmr_count = 13'(POWERUP_CYCLES);
          end else begin
            state_nxt = ST_FIRST;
            tmr_load = 1'b1;
            tmr_count = 13'(FIRST_CYCLES - 2);
          end
        end
      end
      ST_POWERUP: begin
        // The hand-over to the first interval costs one more cycle.
        if (tmr_done) begin
          state_nxt = ST_FIRST;
          tmr_load = 1'b1;
          tmr_count = 13'(FIRST_CYCLES - 3);
        end
      end
      ST_FIRST: begin
        if (tmr_done) begin
          complete = 1'b1;
          ctrl0_nxt[EN_BIT] = 1'b0;
          if (ctrl0_r[CONTINUOUS_SELECT_BIT]) begin
            // The reload cycle itself counts towards the next interval.
            state_nxt = ST_CONTINUOUS_SELECT;
            tmr_load = 1'b1;
            tmr_count = 13'(CADENCE_CYCLES - 1);
          end else begin
            state_nxt = ST_IDLE;
          end
        end
      end
      ST_CONTINUOUS_SELECT: begin
        if (!ctrl0_r[CONTINUOUS_SELECT_BIT]) begin
          state_nxt = ST_IDLE;
          tmr_stop = 1'b1;
        end else if (tmr_done) begin
          complete = 1'b1;
          tmr_load = 1'b1;
          tmr_count = 13'(CADENCE_CYCLES - 1);
        end
      end
      default: begin
        state_nxt = ST_IDLE;
        tmr_stop = 1'b1;
      end
    endcase
    // Result keeps full 13 bits; the top 11 carry the effective value.
    if (complete) begin
      result_nxt = sample_r;
    end
  end

  // Sticky completion flag; a new completion wins over a clear.
  always_comb begin
    status_nxt = status_r;
    if (wr_acc && avs_address == STATUS_ADDR && avs_byteenable[0] &&
        avs_writedata[0]) begin
      status_nxt = 1'b0;
    end
    if (complete) begin
      status_nxt = 1'b1;
    end
    irq_nxt = status_nxt && mask_nxt;
  end

  // Bus answer: one wait cycle, then readdata and waitrequest low.
  always_comb begin
    wait_nxt = 1'b1;
    rdata_nxt = avs_readdata;
    if ((avs_read || avs_write) && wait_r) begin
      wait_nxt = 1'b0;
    end
    if (rd_acc) begin
      rdata_nxt = reg_word(avs_address, ctrl0_r, ctrl1_r, result_r,
                           status_r, mask_r);
    end
  end

  // State registers.
  always_ff @(posedge clock) begin
    if (!reset_n) begin
      state_r <= ST_IDLE;
      ctrl0_r <= CTRL0_RESET;
      ctrl1_r <= CTRL1_RESET;
      result_r <= 13'h0000;
      status_r <= 1'b0;
      mask_r <= 1'b0;
      wait_r <= 1'b1;
      avs_readdata <= 32'h0000_0000;
      irq <= 1'b0;
    end else begin
      state_r <= state_nxt;
      ctrl0_r <= ctrl0_nxt;
      ctrl1_r <= ctrl1_nxt;
      result_r <= result_nxt;
      status_r <= status_nxt;
      mask_r <= mask_nxt;
      wait_r <= wait_nxt;
      avs_readdata <= rdata_nxt;
      irq <= irq_nxt;
    end
  end

  assign avs_waitrequest = wait_r;

  // Analog controls, registered from the control words; power request from the sequencer state.
  always_ff @(posedge clock) begin
    if (!reset_n) begin
      analog_pin_sel <= 3'h0;
      input_select <= 4'h0;
      stage_sel <= STAGE_UNBUF;
      ref_level <= 2'h0;
      reference_out_pin <= 1'b0;
      analog_power_up <= 1'b0;
    end else begin
      analog_pin_sel <= ctrl0_nxt[2:0];
      input_select <= ctrl0_nxt[3:0];
      stage_sel <= stage_code(ctrl0_nxt[BUF_LSB +: 2]);
      ref_level <= {ctrl1_nxt[REFHI_BIT], ctrl0_nxt[REFLO_BIT]};
      reference_out_pin <= ctrl0_nxt[REFOUT_BIT];
      analog_power_up <= (state_nxt != ST_IDLE);
    end
  end

endmodule : conv_ctrl

// ==== tb/analog_front_model.sv ====
`timescale 1ns/1ns
// Analog front end: powers up a cycle after the request and converts level.
module analog_front_model (
  input wire logic clock, // System clock.
  input wire logic reset_n, // Synchronous reset, active low.
  input wire logic power_up, // Power request from the block.
  input wire logic keep_on, // Keep the analog section powered.
  input wire logic [12:0] level, // Sample value to hand over.
  output logic powered, // Analog section is up.
  output logic [12:0] sample // Modulator output.
);
  logic [12:0] junk_r = 13'h0000;
  // Power follows the request; an idle modulator shows a moving pattern.
  always_ff @(posedge clock) begin
    powered <= reset_n & (power_up | keep_on);
    junk_r <= junk_r + 13'h00A5;
  end
  // Only a powered modulator shows a real sample.
  assign sample = powered ? level : junk_r;
endmodule : analog_front_model

// ==== tb/conv_ctrl_chk.sv ====
`timescale 1ns/1ns
// Watches bus timing, routing and interrupt causes at the block's ports.
module conv_ctrl_chk (
  input wire logic clock, // System clock.
  input wire logic reset_n, // Reset, active low.
  input wire logic avs_read, // Read request.
  input wire logic avs_write, // Write request.
  input wire logic avs_waitrequest, // Bus stall.
  input wire logic [31:0] avs_readdata, // Read data.
  input wire logic [3:0] input_select, // Input source code.
  input wire logic [2:0] analog_pin_sel, // Pin select.
  input wire logic [1:0] stage_sel, // Input stage.
  input wire logic [1:0] ref_level, // Reference level.
  input wire logic analog_power_up, // Analog power request.
  input wire logic irq // Interrupt.
);
  default clocking @(posedge clock); endclocking
  default disable iff (!reset_n);
  // Bus answers one edge after a request, for one cycle only.
  wait_one_a: assert property ((avs_read || avs_write) && avs_waitrequest
    |=> !avs_waitrequest) else $error("answer late");
  wait_pulse_a: assert property (!avs_waitrequest |=> avs_waitrequest)
    else $error("answer too long");
  idle_stall_a: assert property (!avs_read && !avs_write |=> avs_waitrequest)
    else $error("answer without request");
  rdata_hold_a: assert property ($changed(avs_readdata) |-> $past(avs_read))
    else $error("read data moved");
  // Routing and settings follow software only.
  pin_route_a: assert property (!input_select[3] |->
    analog_pin_sel == input_select[2:0]) else $error("pin route wrong");
  stage_legal_a: assert property (stage_sel != 2'h3)
    else $error("stage illegal");
  ref_cause_a: assert property ($changed(ref_level) |-> $past(avs_write))
    else $error("reference moved");
  power_cause_a: assert property ($rose(analog_power_up) |->
    $past(avs_write, 2)) else $error("power without start");
  // Interrupt rises only from a running sequencer or a mask write.
  irq_rise_a: assert property ($rose(irq) |-> $past(analog_power_up) ||
    $past(analog_power_up, 2) || $past(avs_write)) else $error("stray irq");
  irq_fall_a: assert property ($fell(irq) |-> $past(avs_write))
    else $error("irq lost");
endmodule : conv_ctrl_chk
bind conv_ctrl conv_ctrl_chk conv_ctrl_chk_inst (.clock(clock),
  .reset_n(reset_n), .avs_read(avs_read), .avs_write(avs_write),
  .avs_waitrequest(avs_waitrequest), .avs_readdata(avs_readdata),
  .input_select(input_select), .analog_pin_sel(analog_pin_sel),
  .stage_sel(stage_sel), .ref_level(ref_level),
  .analog_power_up(analog_power_up), .irq(irq));

// ==== tb/conv_ctrl_bench.sv ====
`timescale 1ns/1ns
// Random and corner-case checks of the converter control block.
module conv_ctrl_bench import conv_ctrl_pkg::*;;
  logic clock, reset_n, avs_read, avs_write, avs_waitrequest, irq, keep_on;
  logic [3:0] avs_address, input_select;
  logic [3:0] avs_byteenable;
  logic [31:0] avs_writedata, avs_readdata;
  logic [12:0] modulator_data, level;
  logic analog_powered, reference_out_pin, analog_power_up;
  logic [2:0] analog_pin_sel;
  logic [1:0] stage_sel, ref_level;
  int fail_count = 0;
  int comparisons = 0;
  conv_ctrl conv_ctrl_inst (.clock(clock), .reset_n(reset_n),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .modulator_data(modulator_data), .analog_powered(analog_powered),
    .analog_pin_sel(analog_pin_sel), .input_select(input_select),
    .stage_sel(stage_sel), .ref_level(ref_level),
    .reference_out_pin(reference_out_pin),
    .analog_power_up(analog_power_up), .irq(irq));
  analog_front_model analog_front_model_inst (.clock(clock),
    .reset_n(reset_n), .power_up(analog_power_up), .keep_on(keep_on),
    .level(level), .powered(analog_powered), .sample(modulator_data));
  // Control word 0 from select, stage and {enable, low, out, continuous}.
  function automatic logic [31:0] cw(input logic [3:0] s,
    input logic [1:0] g, input logic [3:0] f);
    return {22'h0, g, f, s};
  endfunction : cw
  task automatic check(input logic [31:0] seen, input logic [31:0] want);
    comparisons++;
    if (seen !== want) begin
      fail_count++;
      $display("[FAIL] t=%0t seen=%h want=%h", $time, seen, want);
    end
  endtask : check
  task automatic results();
    $display("mismatches %0d of %0d", fail_count, comparisons);
    if (fail_count == 0 && comparisons > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : results
  // One bus cycle held until the edge that samples waitrequest low.
  task automatic bus(input logic wr, input logic [3:0] a,
    input logic [31:0] d, output logic [31:0] q);
    int n;
    n = 0;
    @(posedge clock);
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= wr;
    avs_read <= !wr;
    do begin
      @(posedge clock);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 50);
    if (avs_waitrequest !== 1'b0) fail_count++;
    q = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
  endtask : bus
  task automatic wait_irq(output int n);
    n = 0;
    while (irq !== 1'b1 && n < 6000) begin @(negedge clock); n++; end
  endtask : wait_irq
  // Free-running system clock.
  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end
  // Watchdog cuts a hang short.
  initial begin
    #400000;
    fail_count++;
    results();
  end
  // Main sequence.
  initial begin
    logic [31:0] q, w;
    logic [3:0] s, f;
    logic [1:0] g;
    logic h;
    int n;
    realtime tc;
    void'($urandom(20689));
    {reset_n, avs_read, avs_write, keep_on} = 4'h0;
    avs_address = 4'h0;
    avs_byteenable = 4'hF;
    avs_writedata = 32'h0;
    level = 13'h0;
    repeat (4) @(posedge clock);
    reset_n <= 1'b1;
    bus(1'b1, 4'h2, 32'hFFFF, q);
    for (int i = 0; i < 4; i++) begin
      bus(1'b0, 4'(4 * i + ((i == 3) ? -10 : 0)), 32'h0, q);
      check(q, 32'h0);
    end
    for (int i = 0; i < 6; i++) begin
      s = 4'($urandom_range(7));
      g = 2'($urandom_range(3));
      h = 1'($urandom);
      f = {2'b00, 1'($urandom), 1'b0};
      f[2] = f[1];
      f[1] = h | f[2];
      bus(1'b1, CTRL1_ADDR, {23'h0, 1'b1, 7'h0, h}, q);
      w = cw(s, g, {1'b0, f[2], f[1], 1'b0});
      bus(1'b1, CTRL0_ADDR, w, q);
      bus(1'b0, CTRL0_ADDR, 32'h0, q);
      check(q, w);
      check(32'(analog_pin_sel), 32'(s[2:0]));
      check(32'({input_select, stage_sel, ref_level, reference_out_pin}),
        32'({s, ((g == 2'h3) ? STAGE_UNBUF : g), h, f[2], f[1]}));
    end
    // Lane 1 only: the stage field clears, the low byte is kept.
    avs_byteenable <= 4'h2;
    bus(1'b1, CTRL0_ADDR, 32'h0, q);
    avs_byteenable <= 4'hF;
    bus(1'b0, CTRL0_ADDR, 32'h0, q);
    check(q, w & 32'h0000_00FF);
    check(32'(stage_sel), 32'(STAGE_UNBUF));
    level <= 13'($urandom);
    bus(1'b1, CTRL1_ADDR, 32'h100, q);
    bus(1'b1, CTRL0_ADDR, cw(4'h3, STAGE_BUF, 4'h9), q);
    wait_irq(n);
    // The negedge count runs one past the edge that raises the flag.
    check(32'(n - 1), 32'(FIRST_CYCLES + POWERUP_CYCLES));
    for (int i = 0; i < 3; i++) begin
      tc = $realtime;
      bus(1'b0, DATA_ADDR, 32'h0, q);
      check(q, {16'h0, level, 3'h0});
      bus(1'b0, CTRL0_ADDR, 32'h0, q);
      check(32'(q[EN_BIT]), 32'h0);
      bus(1'b1, STATUS_ADDR, 32'h1, q);
      level <= 13'($urandom);
      repeat (2) @(posedge clock);
      check(32'(irq), 32'h0);
      wait_irq(n);
      check(32'(int'(($realtime - tc) / 10)), CADENCE_CYCLES);
    end
    bus(1'b1, CTRL0_ADDR, cw(4'h3, STAGE_BUF, 4'h0), q);
    repeat (600) @(posedge clock);
    check(32'(irq), 32'h1);
    bus(1'b1, STATUS_ADDR, 32'h1, q);
    repeat (600) @(posedge clock);
    check(32'(irq), 32'h0);
    keep_on <= 1'b1;
    repeat (4) @(posedge clock);
    bus(1'b1, CTRL0_ADDR, cw(4'h5, STAGE_OPAMP, 4'h8), q);
    wait_irq(n);
    check(32'(n - 1), 32'(FIRST_CYCLES));
    bus(1'b1, CTRL1_ADDR, 32'h0, q);
    repeat (2) @(posedge clock);
    check(32'(irq), 32'h0);
    bus(1'b1, CTRL1_ADDR, 32'h100, q);
    repeat (2) @(posedge clock);
    check(32'(irq), 32'h1);
    bus(1'b1, STATUS_ADDR, 32'h1, q);
    repeat (600) @(posedge clock);
    check(32'(irq), 32'h0);
    results();
  end
endmodule : conv_ctrl_bench
